// ===== pth_cfg.svh
`ifndef PTH_CFG_SVH
`define PTH_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define PTH_ADDR_W        3
`define PTH_OFF_COUNT     3'h0
`define PTH_OFF_PERIOD    3'h1
`define PTH_OFF_CONTROL   3'h2
`define PTH_OFF_HLIMIT    3'h3
`define PTH_OFF_RSTSEL    3'h4
`define PTH_OFF_IRQ_STAT  3'h5
`define PTH_OFF_IRQ_CLR   3'h6
`define PTH_OFF_IRQ_EN    3'h7

// ****************************************************************
// field positions
// ****************************************************************
`define PTH_CTRL_RUN_BIT  7
`define PTH_CTRL_PS_MSB   6
`define PTH_CTRL_PS_LSB   4
`define PTH_CTRL_POST_MSB 3
`define PTH_CTRL_POST_LSB 0
`define PTH_IRQ_MATCH     0
`define PTH_IRQ_PULSE     1
`define PTH_IRQ_TRIG      2
`define PTH_IRQ_STOP      3
`define PTH_SRC_MAX       8

// ****************************************************************
// reset values
// ****************************************************************
`define PTH_RST_COUNT     8'h00
`define PTH_RST_PERIOD    8'hFF

`endif

// ===== pth_pkg.sv
`include "pth_cfg.svh"

package pth_pkg;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    PTH_ST_IDLE  = 2'b00,
    PTH_ST_WAIT  = 2'b01,
    PTH_ST_COUNT = 2'b10
  } pth_st_e;

  typedef enum logic [3:0] {
    PTH_M_FREE_SW     = 4'h0,
    PTH_M_FREE_GATE_H = 4'h1,
    PTH_M_FREE_GATE_L = 4'h2,
    PTH_M_FREE_RST_R  = 4'h3,
    PTH_M_FREE_RST_F  = 4'h4,
    PTH_M_FREE_RST_B  = 4'h5,
    PTH_M_FREE_LVL_H  = 4'h6,
    PTH_M_FREE_LVL_L  = 4'h7,
    PTH_M_ONE_SW      = 4'h8,
    PTH_M_ONE_START_R = 4'h9,
    PTH_M_ONE_GATE_H  = 4'hA,
    PTH_M_MONO_R      = 4'hB,
    PTH_M_MONO_F      = 4'hC,
    PTH_M_MONO_B      = 4'hD
  } pth_mode_e;

  typedef struct packed {
    logic gate_en;
    logic gate_pol;
    logic edge_rise;
    logic edge_fall;
    logic lvl_en;
    logic lvl_pol;
    logic start_edge;
    logic one_shot;
    logic mono;
  } pth_modecfg_s;

  typedef struct packed {
    logic [`PTH_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   wr;
    logic                   rd;
  } pth_bus_s;

  typedef struct packed {
    logic [7:0] timer_count;
    logic       tick;
    logic       match;
    logic       running;
  } pth_ccp_s;

  typedef struct packed {
    logic [7:0]              timer_count;
    logic [7:0]              period_value;
    logic                    timer_run_bit;
    logic [2:0]              prescale;
    logic [3:0]              postscale_select;
    logic [3:0]              mode;
    logic [2:0]              reset_source_select;
    logic [6:0]              pre;
    logic [3:0]              post;
    pth_st_e                 st;
    logic                    pulse;
    logic                    tick;
    logic                    match;
    logic                    running;
    logic [3:0]              irq_stat;
    logic [3:0]              irq_en;
    logic [7:0]              rdata;
    logic [`PTH_SRC_MAX-1:0] sync1;
    logic [`PTH_SRC_MAX-1:0] sync2;
    logic                    prev;
    logic                    frz1;
    logic                    frz2;
  } pth_state_s;

endpackage : pth_pkg

// ===== pth_src_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// far-side trigger source
// ****************************************************************
module pth_src_model #(
  parameter int N = 4
) (
  input  wire logic    clk,
  output logic [N-1:0] src
);
  int tick_cnt;

  // idle levels at start
  initial begin
    src = '0;
    tick_cnt = 0;
  end

  // top line toggles as noise, never selected
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 1;
    if (tick_cnt % 8 == 7) src[N-1] <= ~src[N-1];
  end

  // one trigger pulse, level held and edges spaced
  task automatic pulse(input int idx, input int width);
    int w;
    w = (width < 6) ? 6 : width;
    @(posedge clk);
    src[idx] <= 1'b1;
    repeat (w) @(posedge clk);
    src[idx] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : pulse
endmodule : pth_src_model

`default_nettype wire

// ===== pth_timer.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pth_cfg.svh"

module pth_timer
  import pth_pkg::*;
#(
  parameter int N_SRC = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire pth_bus_s         bus,
  output logic [7:0]            rdata,
  input  wire logic [N_SRC-1:0] ext_src,
  input  wire logic             dbg_freeze,
  output logic                  postscaled_pulse_out,
  output pth_ccp_s              capture_compare_pwm_unit,
  output logic                  irq
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (N_SRC < 1 || N_SRC > `PTH_SRC_MAX) begin : g_bad_nsrc
    $error("pth_timer: N_SRC must be 1 to 8");
  end

  // ****************************************************************
  // functions
  // ****************************************************************
  // prescaler terminal count for a 1:2^n division
  function automatic logic [6:0] pth_pre_limit(input logic [2:0] ps);
    logic [7:0] one_hot;
    one_hot = 8'h01 << ps;
    return 7'(one_hot - 8'h01);
  endfunction : pth_pre_limit

  // mode field to behaviour flags
  function automatic pth_modecfg_s pth_decode(input logic [3:0] m);
    pth_modecfg_s c;
    c = '0;
    unique case (pth_mode_e'(m))
      PTH_M_FREE_SW     : c = '0;
      PTH_M_FREE_GATE_H : begin c.gate_en = 1'b1; c.gate_pol = 1'b1; end
      PTH_M_FREE_GATE_L : c.gate_en = 1'b1;
      PTH_M_FREE_RST_R  : c.edge_rise = 1'b1;
      PTH_M_FREE_RST_F  : c.edge_fall = 1'b1;
      PTH_M_FREE_RST_B  : begin c.edge_rise = 1'b1; c.edge_fall = 1'b1; end
      PTH_M_FREE_LVL_H  : begin c.lvl_en = 1'b1; c.lvl_pol = 1'b1; end
      PTH_M_FREE_LVL_L  : c.lvl_en = 1'b1;
      PTH_M_ONE_SW      : c.one_shot = 1'b1;
      PTH_M_ONE_START_R : begin
        c.one_shot = 1'b1; c.start_edge = 1'b1; c.edge_rise = 1'b1;
      end
      PTH_M_ONE_GATE_H  : begin
        c.one_shot = 1'b1; c.gate_en = 1'b1; c.gate_pol = 1'b1;
      end
      PTH_M_MONO_R      : begin
        c.mono = 1'b1; c.start_edge = 1'b1; c.edge_rise = 1'b1;
      end
      PTH_M_MONO_F      : begin
        c.mono = 1'b1; c.start_edge = 1'b1; c.edge_fall = 1'b1;
      end
      PTH_M_MONO_B      : begin
        c.mono = 1'b1; c.start_edge = 1'b1; c.edge_rise = 1'b1; c.edge_fall = 1'b1;
      end
      default           : c = '0; // unused codes run free
    endcase
    return c;
  endfunction : pth_decode

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_n;
  logic rst_sync_n;

  // two flops release the async reset cleanly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ****************************************************************
  // state and next state
  // ****************************************************************
  localparam pth_state_s RST_STATE = '{
    timer_count  : `PTH_RST_COUNT,
    period_value : `PTH_RST_PERIOD,
    st           : PTH_ST_IDLE,
    default      : '0
  };

  pth_state_s              q;
  pth_state_s              d;
  pth_modecfg_s            mc;
  logic [`PTH_SRC_MAX-1:0] ext_pad;
  logic                    frz;
  logic                    sel;
  logic                    edge_trig;
  logic                    gate_ok;
  logic                    lvl_rst;
  logic                    active;
  logic                    tick;
  logic                    is_match;
  logic                    post_hit;
  logic                    sw_clr;
  logic [3:0]              ev;
  logic [3:0]              clr;

  // widen the source bus to the fixed sync width
  always_comb begin
    ext_pad = '0;
    ext_pad[N_SRC-1:0] = ext_src;
  end

  // trigger, gate and tick decode
  always_comb begin
    mc        = pth_decode(q.mode);
    frz       = q.frz2;
    sel       = q.sync2[q.reset_source_select];
    edge_trig = !frz && ((mc.edge_rise && sel && !q.prev) ||
                         (mc.edge_fall && !sel && q.prev));
    gate_ok   = !mc.gate_en || frz || (sel == mc.gate_pol);
    lvl_rst   = mc.lvl_en && !frz && (sel == mc.lvl_pol);
    active    = (q.st == PTH_ST_COUNT) && q.timer_run_bit && gate_ok;
    tick      = active && !lvl_rst && !edge_trig &&
                (q.pre == pth_pre_limit(q.prescale));
    is_match  = q.timer_count == q.period_value;
    post_hit  = q.post == q.postscale_select;
    sw_clr    = bus.wr && (bus.addr == `PTH_OFF_COUNT || bus.addr == `PTH_OFF_CONTROL);
  end

  // next-state logic
  always_comb begin
    d       = q;
    ev      = '0;
    clr     = '0;
    d.tick  = 1'b0;
    d.match = 1'b0;
    d.sync1 = ext_pad;
    d.sync2 = q.sync1;
    d.prev  = sel;
    d.frz1  = dbg_freeze;
    d.frz2  = q.frz1;
    if (tick) begin
      d.pulse = 1'b0;
    end

    // sequencing of the timer
    unique case (q.st)
      PTH_ST_IDLE : begin
        d.pulse = 1'b0;
        if (q.timer_run_bit) begin
          d.st = mc.start_edge ? PTH_ST_WAIT : PTH_ST_COUNT;
        end
      end
      PTH_ST_WAIT : begin
        d.pulse = 1'b0;
        if (!q.timer_run_bit) begin
          d.st = PTH_ST_IDLE;
        end else if (edge_trig) begin
          d.st          = PTH_ST_COUNT;
          d.timer_count = 8'h00;
          d.pre         = 7'h00;
          d.post        = 4'h0;
          ev[`PTH_IRQ_TRIG] = 1'b1;
        end
      end
      PTH_ST_COUNT : begin
        if (!q.timer_run_bit) begin
          d.st    = PTH_ST_IDLE;
          d.pulse = 1'b0;
        end else if (lvl_rst || edge_trig) begin
          d.timer_count = 8'h00;
          d.pre         = 7'h00;
          d.post        = 4'h0;
          ev[`PTH_IRQ_TRIG] = edge_trig;
        end else if (active) begin
          d.pre  = tick ? 7'h00 : 7'(q.pre + 7'h01);
          d.tick = tick;
          if (tick && is_match) begin
            d.timer_count = 8'h00;
            d.match       = 1'b1;
            ev[`PTH_IRQ_MATCH] = 1'b1;
            if (post_hit) begin
              d.post  = 4'h0;
              d.pulse = 1'b1;
              ev[`PTH_IRQ_PULSE] = 1'b1;
            end else begin
              d.post = 4'(q.post + 4'h1);
            end
            if (mc.one_shot) begin
              d.timer_run_bit = 1'b0;
              d.st            = PTH_ST_IDLE;
              ev[`PTH_IRQ_STOP] = 1'b1;
            end else if (mc.mono) begin
              d.st = PTH_ST_WAIT;
              ev[`PTH_IRQ_STOP] = 1'b1;
            end
          end else if (tick) begin
            d.timer_count = 8'(q.timer_count + 8'h01);
          end
        end
      end
      default : begin
        d.st = PTH_ST_IDLE;
      end
    endcase

    // register writes from software
    if (bus.wr) begin
      unique case (bus.addr)
        `PTH_OFF_COUNT : begin
          d.timer_count = bus.wdata;
          d.pre         = 7'h00;
          d.post        = 4'h0;
        end
        `PTH_OFF_PERIOD : d.period_value = bus.wdata;
        `PTH_OFF_CONTROL : begin
          d.timer_run_bit    = bus.wdata[`PTH_CTRL_RUN_BIT];
          d.prescale         = bus.wdata[`PTH_CTRL_PS_MSB:`PTH_CTRL_PS_LSB];
          d.postscale_select = bus.wdata[`PTH_CTRL_POST_MSB:`PTH_CTRL_POST_LSB];
          d.pre              = 7'h00;
          d.post             = 4'h0;
          d.pulse            = d.pulse && bus.wdata[`PTH_CTRL_RUN_BIT];
        end
        `PTH_OFF_HLIMIT : d.mode = bus.wdata[3:0];
        `PTH_OFF_RSTSEL : d.reset_source_select = bus.wdata[2:0];
        `PTH_OFF_IRQ_CLR : clr = bus.wdata[3:0];
        `PTH_OFF_IRQ_EN : d.irq_en = bus.wdata[3:0];
        default : d.irq_en = q.irq_en;                         // status is read-only
      endcase
    end

    // sticky events, a set beats a clear in the same cycle
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.running  = d.st == PTH_ST_COUNT;

    // read data stands only in the cycle after the strobe
    d.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `PTH_OFF_COUNT    : d.rdata = q.timer_count;
        `PTH_OFF_PERIOD   : d.rdata = q.period_value;
        `PTH_OFF_CONTROL  : d.rdata = {q.timer_run_bit, q.prescale, q.postscale_select};
        `PTH_OFF_HLIMIT   : d.rdata = {4'h0, q.mode};
        `PTH_OFF_RSTSEL   : d.rdata = {5'h00, q.reset_source_select};
        `PTH_OFF_IRQ_STAT : d.rdata = {4'h0, q.irq_stat};
        `PTH_OFF_IRQ_EN   : d.rdata = {4'h0, q.irq_en};
        default           : d.rdata = 8'h00;                   // clear register reads zero
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata                = q.rdata;
  assign postscaled_pulse_out = q.pulse;
  assign irq                  = |(q.irq_stat & q.irq_en);
  // live count and period timing for the pwm unit
  assign capture_compare_pwm_unit = '{timer_count : q.timer_count,
                 tick        : q.tick,
                 match       : q.match,
                 running     : q.running};

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  AST_TICK_INCR:
    assert property (tick && !is_match && !sw_clr |=>
                     q.timer_count == $past(q.timer_count) + 8'h01)
    else $error("count did not advance on tick");

  AST_MATCH_WRAP:
    assert property (tick && is_match && !bus.wr |=> q.timer_count == 8'h00 && q.match)
    else $error("count not cleared after period match");

  AST_PULSE_CAUSE:
    assert property ($rose(q.pulse) |-> $past(tick && is_match && post_hit) && q.post == 4'h0)
    else $error("output pulse without postscaler hit");

  AST_GATE_HOLD:
    assert property (q.st == PTH_ST_COUNT && mc.gate_en && !gate_ok && !bus.wr
                     |=> $stable(q.timer_count) && $stable(q.pre))
    else $error("count moved while gate inactive");

  AST_LEVEL_RESET:
    assert property (q.st == PTH_ST_COUNT && q.timer_run_bit && lvl_rst && !bus.wr
                     |=> q.timer_count == 8'h00 && q.pre == 7'h00 && q.post == 4'h0)
    else $error("level reset did not clear the timer");

  AST_COUNT_WRITE:
    assert property (bus.wr && bus.addr == `PTH_OFF_COUNT
                     |=> q.timer_count == $past(bus.wdata) && q.pre == 7'h00 && q.post == 4'h0)
    else $error("count write not taken");

  AST_CTRL_WRITE:
    assert property (bus.wr && bus.addr == `PTH_OFF_CONTROL && q.st == PTH_ST_IDLE
                     |=> $stable(q.timer_count) && q.pre == 7'h00 && q.post == 4'h0)
    else $error("control write disturbed count");

  AST_ONESHOT_STOP:
    assert property (mc.one_shot && tick && is_match && !bus.wr
                     |=> !q.timer_run_bit ##1 q.st == PTH_ST_IDLE)
    else $error("one-shot did not stop");

  AST_MONO_STOP:
    assert property (mc.mono && tick && is_match && !bus.wr
                     |=> q.timer_run_bit && q.st == PTH_ST_WAIT)
    else $error("monostable did not wait with run set");

  AST_FREEZE:
    assert property (frz && !tick && !bus.wr
                     |=> $stable(q.timer_count) &&
                         !($past(q.st) == PTH_ST_WAIT && q.st == PTH_ST_COUNT))
    else $error("trigger taken during freeze");

  AST_IDLE_HOLD:
    assert property (!q.timer_run_bit && !bus.wr
                     |=> $stable(q.timer_count) && !q.pulse && !q.tick)
    else $error("timer moved while stopped");

  AST_PRE_LIMIT:
    assert property (q.st == PTH_ST_COUNT |-> q.pre <= pth_pre_limit(q.prescale))
    else $error("prescaler ran past its terminal count");

  AST_MATCH_POST:
    assert property (tick && is_match && !post_hit && !sw_clr
                     |=> q.post == 4'($past(q.post) + 4'h1))
    else $error("postscaler did not advance on match");

  AST_PULSE_WIDTH:
    assert property (q.pulse && tick && !is_match |=> !q.pulse)
    else $error("output pulse wider than one tick");

  AST_EDGE_RESET:
    assert property (q.st == PTH_ST_COUNT && q.timer_run_bit && edge_trig && !bus.wr
                     |=> q.timer_count == 8'h00 && q.pre == 7'h00 && q.post == 4'h0)
    else $error("edge reset did not clear the timer");

  AST_SW_CLEAR:
    assert property (sw_clr |=> q.pre == 7'h00 && q.post == 4'h0)
    else $error("scalers not cleared by software write");

  AST_CTRL_KEEP:
    assert property (bus.wr && bus.addr == `PTH_OFF_CONTROL && !tick && !edge_trig && !lvl_rst
                     |=> $stable(q.timer_count))
    else $error("control write changed the count");

  AST_WAIT_START:
    assert property (q.st == PTH_ST_WAIT && q.timer_run_bit && edge_trig && !bus.wr
                     |=> q.st == PTH_ST_COUNT && q.timer_count == 8'h00)
    else $error("external edge did not restart the timer");

  AST_RUN_OFF_IDLE:
    assert property (!q.timer_run_bit |=> q.st == PTH_ST_IDLE)
    else $error("timer kept sequencing with run clear");

endmodule : pth_timer

`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pth_cfg.svh"

module tb import pth_pkg::*; ;
  logic       clk;
  logic       rst_n;
  logic       dbg_freeze;
  logic       rd_pend;
  logic       irq;
  logic       pulse;
  pth_bus_s   bus;
  logic [7:0] rdata;
  logic [3:0] ext_src;
  pth_ccp_s   capture_compare_pwm_unit;
  logic [7:0] exp_q[$];
  int         err_count;
  int         checked;
  int         cyc;
  int         mcnt;

  pth_timer #(.N_SRC(4)) dut_u (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .ext_src(ext_src), .dbg_freeze(dbg_freeze), .postscaled_pulse_out(pulse),
    .capture_compare_pwm_unit(capture_compare_pwm_unit), .irq(irq));
  pth_src_model #(.N(4)) src_u (.clk(clk), .src(ext_src));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_byte(nm, {7'h00, e}, {7'h00, g});
  endtask : chk_bit

  task automatic wr(input logic [`PTH_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  // expected read data noted before the strobe
  task automatic rd(input logic [`PTH_ADDR_W-1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
  endtask : rd

  task automatic count_pulses(input int c, output int k);
    k = 0;
    mcnt = 0;
    repeat (c) begin
      @(negedge clk);
      if (pulse === 1'b1) k++;
      if (capture_compare_pwm_unit.match === 1'b1) mcnt++;
    end
  endtask : count_pulses

  // sync to a rising output pulse
  task automatic wait_pulse();
    int t;
    t = 0;
    @(negedge clk);
    while (pulse === 1'b1 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    while (pulse !== 1'b1 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    if (t >= 3000) chk_bit("pulse seen", 1'b1, 1'b0);
  endtask : wait_pulse

  // ****************************************************************
  // clock, monitor, timeout
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) rd_pend <= bus.rd;

  // read data stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_pend === 1'b1 && exp_q.size() > 0) chk_byte("rdata", exp_q.pop_front(), rdata);
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    int p;
    int s;
    int n;
    int k;
    bus = '0;
    dbg_freeze = 1'b0;
    rst_n = 1'b0;
    err_count = 0;
    checked = 0;
    void'($urandom(32'h321568d3));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`PTH_OFF_COUNT, 8'h00);
    rd(`PTH_OFF_PERIOD, 8'hFF);
    rd(`PTH_OFF_CONTROL, 8'h00);
    rd(`PTH_OFF_IRQ_CLR, 8'h00);
    // period and postscale sweep, prescales 1:1 and 1:2
    for (int i = 0; i < 6; i++) begin
      p = $urandom_range(7, 1);
      s = $urandom_range(3, 0);
      n = i % 2;
      wr(`PTH_OFF_PERIOD, 8'(p));
      wr(`PTH_OFF_CONTROL, {1'b1, 3'(n), 4'(s)});
      wr(`PTH_OFF_COUNT, 8'h00);
      wait_pulse();
      count_pulses(3 * (1 << n) * (p + 1) * (s + 1), k);
      chk_byte("pulse cycles", 8'(3 * (1 << n)), 8'(k));
      chk_byte("match cycles", 8'(3 * (s + 1)), 8'(mcnt));
    end
    // stopped timer holds everything
    wr(`PTH_OFF_CONTROL, 8'h00);
    count_pulses(64, k);
    chk_byte("stopped pulses", 8'h00, 8'(k));
    wr(`PTH_OFF_PERIOD, 8'h3C);
    rd(`PTH_OFF_PERIOD, 8'h3C);
    wr(`PTH_OFF_COUNT, 8'h5A);
    wr(`PTH_OFF_CONTROL, 8'h13);
    repeat (20) @(posedge clk);
    rd(`PTH_OFF_COUNT, 8'h5A);
    @(negedge clk);
    chk_byte("ccp count", 8'h5A, capture_compare_pwm_unit.timer_count);
    chk_bit("ccp running", 1'b0, capture_compare_pwm_unit.running);
    // control write mid-prescale restarts the prescaler and postscaler, not the count
    wr(`PTH_OFF_PERIOD, 8'hFF);
    wr(`PTH_OFF_CONTROL, 8'hF0);
    wr(`PTH_OFF_COUNT, 8'h20);
    repeat (100) @(posedge clk);
    wr(`PTH_OFF_CONTROL, 8'hF0);
    repeat (100) @(posedge clk);
    rd(`PTH_OFF_COUNT, 8'h20);
    // one-shot, restarted by cycling run
    wr(`PTH_OFF_HLIMIT, 8'h08);
    wr(`PTH_OFF_PERIOD, 8'h05);
    for (int i = 0; i < 2; i++) begin
      wr(`PTH_OFF_CONTROL, 8'h00);
      wr(`PTH_OFF_COUNT, 8'h00);
      wr(`PTH_OFF_CONTROL, 8'h80);
      count_pulses(40, k);
      chk_byte("one-shot pulses", 8'h01, 8'(k));
      chk_byte("one-shot matches", 8'h01, 8'(mcnt));
      rd(`PTH_OFF_CONTROL, 8'h00);
    end
    // monostable, started by rising edges
    wr(`PTH_OFF_HLIMIT, 8'h0B);
    wr(`PTH_OFF_CONTROL, 8'h80);
    count_pulses(30, k);
    chk_byte("mono idle", 8'h00, 8'(k));
    for (int i = 0; i < 2; i++) begin
      fork
        src_u.pulse(0, 8);
        count_pulses(60, k);
      join
      chk_byte("mono pulses", 8'h01, 8'(k));
      chk_byte("mono matches", 8'h01, 8'(mcnt));
    end
    rd(`PTH_OFF_CONTROL, 8'h80);
    // edge and level reset modes, two sources
    wr(`PTH_OFF_PERIOD, 8'hFF);
    wr(`PTH_OFF_CONTROL, 8'hF0);
    for (int m = 3; m < 8; m++) begin
      wr(`PTH_OFF_HLIMIT, 8'(m));
      wr(`PTH_OFF_RSTSEL, 8'(m % 2));
      wr(`PTH_OFF_COUNT, 8'h40);
      src_u.pulse(m % 2, 8);
      rd(`PTH_OFF_COUNT, 8'h00);
    end
    // triggers ignored under debug freeze
    wr(`PTH_OFF_HLIMIT, 8'h03);
    wr(`PTH_OFF_RSTSEL, 8'h00);
    dbg_freeze <= 1'b1;
    repeat (3) @(posedge clk);
    wr(`PTH_OFF_COUNT, 8'h40);
    src_u.pulse(0, 8);
    rd(`PTH_OFF_COUNT, 8'h40);
    dbg_freeze <= 1'b0;
    // gate-high mode halts while gate idles low
    wr(`PTH_OFF_HLIMIT, 8'h01);
    wr(`PTH_OFF_CONTROL, 8'h80);
    wr(`PTH_OFF_COUNT, 8'h10);
    repeat (20) @(posedge clk);
    rd(`PTH_OFF_COUNT, 8'h10);
    @(negedge clk);
    chk_bit("ccp running", 1'b1, capture_compare_pwm_unit.running);
    chk_bit("ccp tick", 1'b0, capture_compare_pwm_unit.tick);
    // interrupt masked, enabled, cleared
    wr(`PTH_OFF_CONTROL, 8'hF0);
    wr(`PTH_OFF_HLIMIT, 8'h03);
    wr(`PTH_OFF_IRQ_EN, 8'h00);
    wr(`PTH_OFF_IRQ_CLR, 8'h0F);
    wr(`PTH_OFF_IRQ_STAT, 8'hFF);
    src_u.pulse(0, 8);
    @(negedge clk);
    chk_bit("irq masked", 1'b0, irq);
    rd(`PTH_OFF_IRQ_STAT, 8'h04);
    wr(`PTH_OFF_IRQ_EN, 8'h04);
    @(negedge clk);
    chk_bit("irq set", 1'b1, irq);
    wr(`PTH_OFF_IRQ_CLR, 8'h04);
    @(negedge clk);
    chk_bit("irq cleared", 1'b0, irq);
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule : tb

`default_nettype wire
